// [shared/isd_pkg.sv]
// Shared constants for the interconnect space decoder
package isd_pkg;
  localparam int ADDR_W      = 16;
  localparam int SLOT_W      = 5;
  localparam int REGN_W      = 9;
  localparam int DATA_W      = 8;
  localparam int SLOT_MSB    = 15;
  localparam int SLOT_LSB    = 11;
  localparam int REGN_MSB    = 10;
  localparam int REGN_LSB    = 2;
  localparam int REG_COUNT   = 512;
  // Register numbers
  localparam logic [8:0] VENDOR_LOW_REG  = 9'h000;
  localparam logic [8:0] VENDOR_HIGH_REG = 9'h001;
  localparam logic [8:0] FIRST_USER_REG  = 9'h002;
  // Legal slot ranges per bus
  localparam logic [4:0] PSB_SLOT_MIN = 5'h00;
  localparam logic [4:0] PSB_SLOT_MAX = 5'h13;
  localparam logic [4:0] LBX_SLOT_MIN = 5'h18;
  localparam logic [4:0] LBX_SLOT_MAX = 5'h1d;
  localparam logic [4:0] CSA_SLOT     = 5'h00;
  localparam logic [4:0] PRIMARY_SLOT = 5'h18;
  localparam logic [7:0] DATA_ZERO    = 8'h00;
  localparam logic [1:0] LOW_ZERO     = 2'h0;
  // Register access classes
  typedef enum logic [1:0] {
    ISD_ACC_NONE = 2'b00,
    ISD_ACC_RW   = 2'b01,
    ISD_ACC_WO   = 2'b10,
    ISD_ACC_RO   = 2'b11
  } isd_acc_t;
endpackage

// [rtl/isd_user_regs.sv]
// User-defined register array with per-register access class
`timescale 1ns/1ps
module isd_user_regs #(
  parameter int NUM_REGS = 16
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   wr_en,
  input  wire logic [8:0]             wr_idx,
  input  wire logic [7:0]             wr_data,
  input  wire logic [8:0]             rd_idx,
  output logic      [7:0]             rd_data,
  output logic                        rd_ok,
  output logic                        wr_pulse,
  output logic [NUM_REGS*8-1:0]       reg_flat
);
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] mem;
    logic                     pulse;
  } isd_ur_state_t;

  isd_ur_state_t s_q;
  isd_ur_state_t s_d;

  // Fixed access layout: every 4th index (low bits 2'h3) write-only, all other indices from 2 to NUM_REGS+1 read/write
  function automatic isd_pkg::isd_acc_t acc_of(input logic [8:0] idx);
    if (idx < isd_pkg::FIRST_USER_REG ||
        idx >= 9'(NUM_REGS + 2)) begin
      return isd_pkg::ISD_ACC_NONE;
    end else if (idx[1:0] == 2'h3) begin
      return isd_pkg::ISD_ACC_WO;
    end else begin
      return isd_pkg::ISD_ACC_RW;
    end
  endfunction

  initial begin
    if (NUM_REGS < 1 || NUM_REGS > 510) begin
      $error("isd_user_regs: NUM_REGS out of range");
    end
  end

  // Next-state: store writable registers, pulse on write-only strobe
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    if (wr_en && acc_of(wr_idx) == isd_pkg::ISD_ACC_RW) begin
      s_d.mem[wr_idx - isd_pkg::FIRST_USER_REG] = wr_data;
    end
    if (wr_en && acc_of(wr_idx) == isd_pkg::ISD_ACC_WO) begin
      s_d.pulse = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Read is combinational; caller registers it
  always_comb begin
    rd_data = isd_pkg::DATA_ZERO;
    rd_ok   = 1'b0;
    if (acc_of(rd_idx) == isd_pkg::ISD_ACC_RW) begin
      rd_data = s_q.mem[rd_idx - isd_pkg::FIRST_USER_REG];
      rd_ok   = 1'b1;
    end
  end

  assign wr_pulse = s_q.pulse;
  assign reg_flat = s_q.mem;
endmodule // isd_user_regs

// [rtl/isd_decoder.sv]
// Interconnect space decoder: slot match and byte register access
`timescale 1ns/1ps
// Contract
// - Each transfer moves exactly one byte
// - Replier accepts reads and writes
// - Access only one of 512 registers
// - Single point-to-point access, no bursts
// - System bus slots 0 to 19, slot 0 central
// - Extension bus slots 24 to 29, 24 primary
// - Address 16 bits: slot, register, two zeros
// - Own slot ID captured at power-up
// - Both buses may share one register set
// - Registers 0 and 1 hold vendor code
// - Writes to vendor registers silently ignored
// - Registers 2 to 511 optional, user-defined
// - System bus compares with assigned slot
// - Extension bus compares with dedicated value
// - Mismatch never reaches local receiver
// - Match performs read or write on register
module isd_decoder #(
  parameter logic [15:0] VENDOR_CODE = 16'h5aa5,  // Arbitrary value
  parameter logic [4:0]  LBX_OWN_ID  = 5'h19,
  parameter int          USER_REGS   = 16
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [4:0]  slot_strap,
  input  wire logic        psb_req,
  input  wire logic [15:0] psb_addr,
  input  wire logic        psb_write,
  input  wire logic [7:0]  psb_wdata,
  input  wire logic        lbx_req,
  input  wire logic [15:0] lbx_addr,
  input  wire logic        lbx_write,
  input  wire logic [7:0]  lbx_wdata,
  output logic             psb_ack,
  output logic             lbx_ack,
  output logic [7:0]       rdata,
  output logic             rx_valid,
  output logic             rx_write,
  output logic [8:0]       rx_regnum,
  output logic [7:0]       rx_wdata,
  output logic             user_strobe,
  output logic             slot_invalid
);
  typedef enum logic [1:0] {
    ISD_ST_STRAP = 2'b00,
    ISD_ST_IDLE  = 2'b01,
    ISD_ST_DONE  = 2'b10
  } isd_st_t;

  typedef struct packed {
    isd_st_t    st;
    logic [4:0] own_slot;
    logic       psb_ack;
    logic       lbx_ack;
    logic [7:0] rdata;
    logic       rx_valid;
    logic       rx_write;
    logic [8:0] rx_regnum;
    logic [7:0] rx_wdata;
    logic       slot_invalid;
  } isd_state_t;

  isd_state_t s_q;
  isd_state_t s_d;

  initial begin
    if (USER_REGS < 1 || USER_REGS > isd_pkg::REG_COUNT - 2) begin
      $error("isd_decoder: USER_REGS out of range");
    end
    if (LBX_OWN_ID < isd_pkg::LBX_SLOT_MIN ||
        LBX_OWN_ID > isd_pkg::LBX_SLOT_MAX) begin
      $error("isd_decoder: LBX_OWN_ID outside 24..29");
    end
  end

  // Strap pins pass three flops; change counted when last two agree
  logic [4:0] strap_s1;
  logic [4:0] strap_s2;
  logic [4:0] strap_s3;
  // Fill marks stages that hold pin samples, so reset zeros in the
  // synchroniser are never mistaken for a settled slot number
  logic [2:0] strap_fill;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_s1   <= '0;
      strap_s2   <= '0;
      strap_s3   <= '0;
      strap_fill <= '0;
    end else begin
      strap_s1   <= slot_strap;
      strap_s2   <= strap_s1;
      strap_s3   <= strap_s2;
      strap_fill <= {strap_fill[1:0], 1'b1};
    end
  end

  // Field extraction shared by both buses
  function automatic logic [4:0] slot_of(input logic [15:0] a);
    return a[isd_pkg::SLOT_MSB:isd_pkg::SLOT_LSB];
  endfunction
  function automatic logic [8:0] reg_of(input logic [15:0] a);
    return a[isd_pkg::REGN_MSB:isd_pkg::REGN_LSB];
  endfunction
  function automatic logic low_ok(input logic [15:0] a);
    return a[1:0] == isd_pkg::LOW_ZERO;
  endfunction

  // One shared register set serves both buses
  logic [7:0]                 ur_rdata;
  logic                       ur_rd_ok;
  logic                       ur_wr_en;
  logic [USER_REGS*8-1:0]     ur_flat;

  // Arbitration and decode
  logic        sel_psb;
  logic        sel_lbx;
  logic [15:0] cur_addr;
  logic        cur_write;
  logic [7:0]  cur_wdata;
  logic        hit;
  logic [8:0]  cur_reg;
  always_comb begin
    // System bus wins a tie; the loser waits for its ack
    sel_psb   = psb_req && !s_q.psb_ack && !s_q.lbx_ack &&
                s_q.st == ISD_ST_IDLE;
    sel_lbx   = lbx_req && !sel_psb && !s_q.psb_ack && !s_q.lbx_ack &&
                s_q.st == ISD_ST_IDLE;
    cur_addr  = sel_psb ? psb_addr  : lbx_addr;
    cur_write = sel_psb ? psb_write : lbx_write;
    cur_wdata = sel_psb ? psb_wdata : lbx_wdata;
    cur_reg   = reg_of(cur_addr);
    // Own assigned slot vs dedicated value per bus
    hit = (sel_psb && slot_of(cur_addr) == s_q.own_slot) ||
          (sel_lbx && slot_of(cur_addr) == LBX_OWN_ID);
    hit = hit && low_ok(cur_addr);
  end

  assign ur_wr_en = hit && cur_write;  // vendor regs never stored

  isd_user_regs #(
    .NUM_REGS (USER_REGS)
  ) u_user (
    .mclk     (mclk),
    .nrst     (nrst),
    .wr_en    (ur_wr_en),
    .wr_idx   (cur_reg),
    .wr_data  (cur_wdata),
    .rd_idx   (cur_reg),
    .rd_data  (ur_rdata),
    .rd_ok    (ur_rd_ok),
    .wr_pulse (user_strobe),
    .reg_flat (ur_flat)
  );

  // Main next-state logic
  always_comb begin
    s_d          = s_q;
    s_d.psb_ack  = 1'b0;
    s_d.lbx_ack  = 1'b0;
    s_d.rx_valid = 1'b0;
    case (s_q.st)
      ISD_ST_STRAP: begin
        // Slot captured once after reset release, when stable
        if (strap_fill[2] && strap_s2 == strap_s3) begin
          s_d.own_slot     = strap_s3;
          s_d.slot_invalid = strap_s3 > isd_pkg::PSB_SLOT_MAX;
          s_d.st           = ISD_ST_IDLE;
        end
      end
      ISD_ST_IDLE: begin
        // Each request is one beat; no address increment exists
        if (sel_psb || sel_lbx) begin
          s_d.psb_ack = sel_psb;
          s_d.lbx_ack = sel_lbx;
          s_d.rdata   = isd_pkg::DATA_ZERO;
          if (hit) begin
            s_d.rx_valid  = 1'b1;
            s_d.rx_write  = cur_write;
            s_d.rx_regnum = cur_reg;
            s_d.rx_wdata  = cur_wdata;
            if (!cur_write) begin
              if (cur_reg == isd_pkg::VENDOR_LOW_REG) begin
                s_d.rdata = VENDOR_CODE[7:0];
              end else if (cur_reg == isd_pkg::VENDOR_HIGH_REG) begin
                s_d.rdata = VENDOR_CODE[15:8];
              end else if (ur_rd_ok) begin
                s_d.rdata = ur_rdata;
              end
            end
          end
          s_d.st = ISD_ST_DONE;
        end
      end
      ISD_ST_DONE: begin
        // One idle cycle lets the requester drop its request
        s_d.st = ISD_ST_IDLE;
      end
      default: begin
        s_d.st = ISD_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign psb_ack      = s_q.psb_ack;
  assign lbx_ack      = s_q.lbx_ack;
  assign rdata        = s_q.rdata;
  assign rx_valid     = s_q.rx_valid;
  assign rx_write     = s_q.rx_write;
  assign rx_regnum    = s_q.rx_regnum;
  assign rx_wdata     = s_q.rx_wdata;
  assign slot_invalid = s_q.slot_invalid;

  // Checks; each label names the behaviour it guards
  a_vendor_low_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    (hit && !cur_write && cur_reg == isd_pkg::VENDOR_LOW_REG)
    |=> rdata == VENDOR_CODE[7:0])
    else $error("vendor low byte wrong");
  a_vendor_high_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    (hit && !cur_write && cur_reg == isd_pkg::VENDOR_HIGH_REG)
    |=> rdata == VENDOR_CODE[15:8])
    else $error("vendor high byte wrong");
  a_vendor_no_store: assert property (
    @(posedge mclk) disable iff (!nrst)
    (ur_wr_en && cur_reg < isd_pkg::FIRST_USER_REG)
    |=> $stable(ur_flat) && !user_strobe)
    else $error("vendor write changed storage");
  a_miss_no_fwd: assert property (
    @(posedge mclk) disable iff (!nrst)
    ((sel_psb || sel_lbx) && !hit) |=> !rx_valid)
    else $error("mismatch forwarded");
  a_psb_match_fwd: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_psb && slot_of(psb_addr) == s_q.own_slot && low_ok(psb_addr))
    |=> rx_valid && rx_regnum == $past(cur_reg))
    else $error("system bus match not forwarded");
  a_lbx_match_fwd: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_lbx && slot_of(lbx_addr) == LBX_OWN_ID && low_ok(lbx_addr))
    |=> rx_valid && rx_write == $past(lbx_write))
    else $error("extension bus match not forwarded");
  sequence s_beat;
    psb_ack || lbx_ack;
  endsequence
  // After a beat the decoder rests one cycle before it takes again
  sequence s_rest;
    !psb_ack && !lbx_ack && s_q.st == ISD_ST_IDLE;
  endsequence
  a_single_beat: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_beat |=> s_rest)
    else $error("back to back beats");
  a_req_answered: assert property (
    @(posedge mclk) disable iff (!nrst)
    (psb_req && s_q.st == ISD_ST_IDLE && !psb_ack && !lbx_ack)
    |=> psb_ack)
    else $error("request not answered");
  a_user_rw_back: assert property (
    @(posedge mclk) disable iff (!nrst)
    (ur_wr_en && cur_reg == isd_pkg::FIRST_USER_REG)
    |=> ur_flat[7:0] == $past(cur_wdata))
    else $error("user write lost");
  a_acks_exclusive: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(psb_ack && lbx_ack))
    else $error("both buses acked at once");
  // A tie must leave the extension bus waiting, not served in parallel
  a_psb_wins_tie: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_psb && lbx_req) |=> psb_ack && !lbx_ack)
    else $error("tie not won by system bus");
  a_wdata_carried: assert property (
    @(posedge mclk) disable iff (!nrst)
    (hit && cur_write) |=> rx_write && rx_wdata == $past(cur_wdata))
    else $error("write byte not forwarded");
  a_wo_strobe: assert property (
    @(posedge mclk) disable iff (!nrst)
    (ur_wr_en && cur_reg >= isd_pkg::FIRST_USER_REG &&
     cur_reg < USER_REGS + 2 && cur_reg[1:0] == 2'h3)
    |=> user_strobe)
    else $error("write-only strobe missing");
  a_slot_flag: assert property (
    @(posedge mclk) disable iff (!nrst)
    (s_q.st == ISD_ST_IDLE)
    |-> slot_invalid == (s_q.own_slot > isd_pkg::PSB_SLOT_MAX))
    else $error("slot range flag wrong");
  // Capture happens only once the synchroniser holds agreeing samples
  sequence s_strap_ready;
    s_q.st == ISD_ST_STRAP && strap_fill[2] && strap_s2 == strap_s3;
  endsequence
  a_strap_capture: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_strap_ready
    |=> s_q.st == ISD_ST_IDLE && s_q.own_slot == $past(strap_s3))
    else $error("slot strap not captured");
endmodule // isd_decoder

// [verification/isd_requester.sv]
// Requesting agent model for one backplane bus
`timescale 1ns/1ps
module isd_requester (
  input  wire logic        mclk,
  output logic             req,
  output logic [15:0]      addr,
  output logic             write,
  output logic [7:0]       wdata,
  input  wire logic        ack,
  input  wire logic [7:0]  rdata
);
  initial begin
    req   = 1'b0;
    addr  = 16'h5555;
    write = 1'b0;
    wdata = 8'ha5;
  end

  // One byte per access, held until the ack edge, then released at once
  task automatic xfer(input logic [4:0] s, input logic [8:0] r,
                      input logic w, input logic [7:0] d, input int gap,
                      output logic [7:0] q, output bit tmo);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge mclk);
    #2;
    req   = 1'b1;
    addr  = {s, r, 2'h0};
    write = w;
    wdata = d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q   = rdata;
    tmo = (n >= 40);
    #2;
    req   = 1'b0;
    // Released address and data lines must not keep showing the last value
    addr  = ~addr;
    wdata = ~wdata;
  endtask
endmodule // isd_requester

// [verification/test_interconnect_space_decoder.sv]
// Self-checking bench for the interconnect space decoder
`timescale 1ns/1ps
module test_interconnect_space_decoder;
  localparam logic [15:0] VCODE = 16'h3ce1; // Arbitrary vendor code
  localparam logic [4:0]  OWN_X = 5'h19;
  localparam int          NREG  = 16;
  logic        mclk, nrst, p_req, p_wr, l_req, l_wr, p_ack, l_ack;
  logic        rx_valid, rx_write, user_strobe, slot_invalid;
  logic [4:0]  strap;
  logic [15:0] p_addr, l_addr;
  logic [7:0]  p_wd, l_wd, rdata, rx_wdata, q1, q2;
  logic [8:0]  rx_regnum;
  logic [31:0] seed;
  logic [7:0]  mem [0:511];
  bit          t1, t2;
  int          n_errors, total_checks, cyc, n_rx, n_us, r0;

  isd_decoder #(.VENDOR_CODE(VCODE), .LBX_OWN_ID(OWN_X), .USER_REGS(NREG))
  u_dut (.mclk(mclk), .nrst(nrst), .slot_strap(strap), .psb_req(p_req),
    .psb_addr(p_addr), .psb_write(p_wr), .psb_wdata(p_wd), .lbx_req(l_req),
    .lbx_addr(l_addr), .lbx_write(l_wr), .lbx_wdata(l_wd), .psb_ack(p_ack),
    .lbx_ack(l_ack), .rdata(rdata), .rx_valid(rx_valid),
    .rx_write(rx_write), .rx_regnum(rx_regnum), .rx_wdata(rx_wdata),
    .user_strobe(user_strobe), .slot_invalid(slot_invalid));
  isd_requester u_psb (.mclk(mclk), .req(p_req), .addr(p_addr),
    .write(p_wr), .wdata(p_wd), .ack(p_ack), .rdata(rdata));
  isd_requester u_lbx (.mclk(mclk), .req(l_req), .addr(l_addr),
    .write(l_wr), .wdata(l_wd), .ack(l_ack), .rdata(rdata));

  always #25 mclk = ~mclk;

  // Pulse counters and hang guard
  always @(posedge mclk) begin
    cyc++;
    n_rx += (rx_valid === 1'b1);
    n_us += (user_strobe === 1'b1);
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference read value from the register model
  function automatic logic [7:0] exp_rd(input logic [8:0] r);
    if (r < 2) return r[0] ? VCODE[15:8] : VCODE[7:0];
    if (r > NREG + 1 || r[1:0] == 2'h3) return 8'h00;
    return mem[r];
  endfunction

  task automatic do_reset(input logic [4:0] s);
    #2 nrst = 1'b0;
    strap = s;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(posedge mclk);
    #2 nrst = 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  // One access through a requester, compared against the model
  task automatic op(input bit x, input logic [4:0] s, input logic [8:0] r,
                    input logic w, input logic [7:0] d, input int gap);
    logic [7:0] q;
    bit         tmo, hit, wo;
    int         rx0, us0;
    hit = x ? (s == OWN_X) : (s == strap);
    wo  = w && hit && r > 1 && r <= NREG + 1 && r[1:0] == 2'h3;
    rx0 = n_rx;
    us0 = n_us;
    if (x) u_lbx.xfer(s, r, w, d, gap, q, tmo);
    else u_psb.xfer(s, r, w, d, gap, q, tmo);
    chk("timeout", 0, tmo);
    chk("rdata", w || !hit ? 8'h00 : exp_rd(r), q);
    chk("rx_valid", hit, n_rx - rx0);
    chk("user_strobe", wo, n_us - us0);
    if (hit) begin
      chk("rx_op", {w, r, d}, {rx_write, rx_regnum, rx_wdata});
    end
    if (hit && w && r > 1 && r <= NREG + 1 && r[1:0] != 2'h3) mem[r] = d;
  endtask

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    strap = 5'h07;
    seed = 32'h0000_0048;
    do_reset(5'h07);
    chk("slot_invalid", 0, slot_invalid);
    // Vendor code on both buses
    for (int i = 0; i < 2; i++) begin
      op(0, 5'h07, i, 0, 8'h00, 0);
      op(1, OWN_X, i, 0, 8'h00, 3);
    end
    // Vendor registers ignore writes
    op(0, 5'h07, 0, 1, 8'hff, 0);
    op(1, OWN_X, 1, 1, 8'h00, 0);
    op(0, 5'h07, 0, 0, 8'h00, 0);
    op(1, OWN_X, 1, 0, 8'h00, 0);
    $display("test vendor done");
    // Random traffic over one shared register set
    for (int i = 0; i < 60; i++) begin
      seed = rnd();
      op(seed[0], seed[0] ? OWN_X : 5'h07,
         seed[20] ? 9'h1ff : {4'h0, seed[12:8]},
         seed[1], seed[31:24], seed[3:2]);
    end
    $display("test random done");
    // Foreign slots never reach the receiver
    op(0, 5'h13, 2, 1, 8'h5a, 0);
    op(0, OWN_X, 2, 0, 8'h00, 0);
    op(1, 5'h18, 2, 1, 8'h5a, 0);
    op(1, 5'h07, 0, 0, 8'h00, 0);
    op(0, 5'h07, 2, 0, 8'h00, 0);
    $display("test mismatch done");
    // Both buses request in the same cycle
    r0 = n_rx;
    fork
      u_psb.xfer(5'h07, 9'h002, 1, 8'h11, 0, q1, t1);
      u_lbx.xfer(OWN_X, 9'h004, 1, 8'h22, 0, q2, t2);
    join
    chk("both_taken", 2, n_rx - r0);
    chk("collide_tmo", 0, {t1, t2});
    chk("collide_rd", 0, {q1, q2});
    mem[2] = 8'h11;
    mem[4] = 8'h22;
    op(1, OWN_X, 2, 0, 8'h00, 0);
    op(0, 5'h07, 4, 0, 8'h00, 0);
    $display("test collision done");
    // Reset again with a slot beyond the system bus range
    do_reset(5'h14);
    chk("slot_invalid", 1, slot_invalid);
    op(0, 5'h14, 0, 0, 8'h00, 0);
    op(1, OWN_X, 2, 0, 8'h00, 0);
    $display("test strap done");
    conclude();
  end
endmodule // test_interconnect_space_decoder
